// *** inc/mosr_pkg.sv ***
package mosr_pkg;
	// ----------------------------------------
	// register map: word index per status byte, byte address is index*4
	// ----------------------------------------
	localparam logic [7:0] IDX_NEG = 8'h0C;
	localparam logic [7:0] IDX_LOOP = 8'h0D;
	localparam logic [7:0] IDX_HSHK = 8'h0E;
	localparam logic [7:0] IDX_CTRL = 8'h10;
	localparam logic [11:0] ADDR_NEG = {2'b00, IDX_NEG, 2'b00};
	localparam logic [11:0] ADDR_LOOP = {2'b00, IDX_LOOP, 2'b00};
	localparam logic [11:0] ADDR_HSHK = {2'b00, IDX_HSHK, 2'b00};
	localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int NEG_DONE_BIT = 0;
	localparam int SPD_LSB = 1;
	localparam int SPD_MSB = 4;
	localparam int LOOP_V54D = 0;
	localparam int LOOP_V54E = 1;
	localparam int LOOP_ALT = 2;
	localparam int LOOP_LOOP = 3;
	localparam int PH_ECHO = 0;
	localparam int PH_REV = 1;
	localparam int PH_TRAIN = 2;
	localparam int PH_RATE = 3;
	localparam int PH_SCR1 = 4;
	localparam int PH_TDET = 5;
	localparam int PH_RDET = 6;
	localparam int PH_SUCC = 7;
	// ----------------------------------------
	// codes, reset values, timing
	// ----------------------------------------
	localparam logic [3:0] SPD_1200 = 4'h2;
	localparam logic [3:0] SPD_12000 = 4'h7;
	localparam logic [3:0] SPD_14400 = 4'h8;
	localparam logic [3:0] SPD_MAX = 4'h8;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] ECHO_T_MS = 8'hC0;
	localparam int V54_DET_BITS = 256;
	localparam int RETRAIN_BAUDS = 256;
	localparam int CLK_HZ = 10000000;
	localparam int ECHO_CYC = (CLK_HZ / 1000) * ECHO_T_MS;
	typedef enum logic [3:0] {
		MOSR_IDLE = 4'b0001,
		MOSR_DATA = 4'b0010,
		MOSR_FAXT = 4'b0100,
		MOSR_FAXR = 4'b1000
	} mosr_mode_e;
	typedef enum logic [2:0] {
		MOSR_STD_V17 = 3'h0,
		MOSR_STD_V33 = 3'h1,
		MOSR_STD_V29 = 3'h2,
		MOSR_STD_V27 = 3'h3,
		MOSR_STD_V21 = 3'h4
	} mosr_std_e;
endpackage

// *** hw/mosr_count.sv ***
`timescale 1ns/100ps
`default_nettype none
// saturating event counter: done when LIMIT qualifying events have been seen
module mosr_count #(
	parameter int LIMIT = 256
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic step,
	output logic done
);
	// the counter is 16 bits wide
	if (LIMIT < 1 || LIMIT > 65535) begin : g_bad_limit
		$error("mosr_count LIMIT out of range");
	end
	logic [15:0] cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			done <= 1'b0;
		end else if (clear) begin
			cnt <= 16'h0000;
			done <= 1'b0;
		end else if (step && !done) begin
			cnt <= cnt + 16'h0001;
			done <= (cnt == 16'(LIMIT - 1));
		end
	end
endmodule
`default_nettype wire

// *** hw/mosr_status.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// - negotiation done bit clear during negotiation
// - speed code in bits four to one
// - loop detect after 256 received bits
// - loop sent bit when transmit pattern ends
// - alternating pattern seen sets bit two
// - loop pattern seen sets bit three
// - data mode handshake event code byte
// - fax training phase flags bits zero-four
// - receiver detection flags bits five, six
// - training success flag in bit seven
// - no rate flags in V.29, V.27
// - success resampled 256 bauds after ones fall
// - sync zero clears all phase flags
// - sync one sets selected phase flag
// - V.33 receiver reports speed 8 or 7
// - speed valid with scrambled ones rise in V.33 receive
// - echo interval 192 ms if long tone
// - configuration reloads mode defaults
module mosr_status (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CONFIG_CMD,
	input wire logic [3:0] CONFIG_MODE,
	input wire logic [2:0] CONFIG_STD,
	input wire logic NEG_ACTIVE,
	input wire logic NEG_DONE,
	input wire logic [3:0] NEGOTIATED_SPEED_CODE,
	input wire logic RX_BIT_STB,
	input wire logic RX_V54_MATCH,
	input wire logic TX_V54_END,
	input wire logic ALT_PATTERN_SEEN,
	input wire logic LOOP_PATTERN_SEEN,
	input wire logic HSHK_EVENT_STB,
	input wire logic [7:0] HSHK_EVENT_CODE,
	input wire logic BAUD_STB,
	input wire logic [4:0] TX_PHASE,
	input wire logic [1:0] RX_PHASE,
	input wire logic RX_TRAIN_DET,
	input wire logic RX_RATE_DET,
	input wire logic RX_TRAIN_END,
	input wire logic EQ_QUALITY_OK,
	input wire logic RX_RATE_14400,
	input wire logic SYNC_ZERO,
	input wire logic SYNC_ONE,
	input wire logic [2:0] SYNC_ONE_SEL,
	output logic SPEED_VALID,
	output logic ECHO_GUARD_ACTIVE
);
	logic rst_a;
	logic rst_n;
	logic ones_rise;
	logic ones_fall;
	mosr_pkg::mosr_mode_e cur_mode;
	mosr_pkg::mosr_std_e cur_std;
	logic long_echo;
	logic [7:0] neg_reg;
	logic [7:0] loop_reg;
	logic [7:0] hshk_reg;
	logic [7:0] phase;
	logic scr1_d;
	logic retrain_armed;
	logic retrain_done;
	logic v54_done;
	logic echo_start;
	logic [31:0] echo_cnt;
	logic no_rate;
	logic apb_set;
	logic [7:0] sel_reg;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	function automatic logic [7:0] read_mux(input logic [11:0] a, input logic [7:0] n,
		input logic [7:0] l, input logic [7:0] h, input logic [7:0] c);
		unique case (a)
			mosr_pkg::ADDR_NEG: read_mux = n;
			mosr_pkg::ADDR_LOOP: read_mux = l;
			mosr_pkg::ADDR_HSHK: read_mux = h;
			mosr_pkg::ADDR_CTRL: read_mux = c;
			default: read_mux = 8'h00;
		endcase
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == mosr_pkg::ADDR_NEG) || (a == mosr_pkg::ADDR_LOOP) ||
			(a == mosr_pkg::ADDR_HSHK) || (a == mosr_pkg::ADDR_CTRL);
	endfunction

	// flag index of either rate sequence flag
	function automatic logic rate_bit(input logic [2:0] s);
		rate_bit = (s == 3'(mosr_pkg::PH_RATE)) || (s == 3'(mosr_pkg::PH_RDET));
	endfunction

	// ----------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------
	assign apb_set = PSEL && !PENABLE;
	assign sel_reg = {3'b000, long_echo, 1'b0, cur_std};
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= apb_set;
			PSLVERR <= apb_set && (!mapped(PADDR) || (PWRITE && PADDR != mosr_pkg::ADDR_CTRL));
			if (apb_set && !PWRITE) begin
				PRDATA <= {24'h000000, read_mux(PADDR, neg_reg, loop_reg, hshk_reg, sel_reg)};
			end else begin
				PRDATA <= 32'h00000000;
			end
		end
	end

	// long echo tone choice is the only host-writable control
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			long_echo <= 1'b0;
		end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == mosr_pkg::ADDR_CTRL) begin
			long_echo <= PWDATA[4];
		end
	end

	// ----------------------------------------
	// mode latch
	// ----------------------------------------
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			cur_mode <= mosr_pkg::MOSR_IDLE;
			cur_std <= mosr_pkg::MOSR_STD_V17;
		end else if (CONFIG_CMD) begin
			unique case (CONFIG_MODE)
				4'b0010: cur_mode <= mosr_pkg::MOSR_DATA;
				4'b0100: cur_mode <= mosr_pkg::MOSR_FAXT;
				4'b1000: cur_mode <= mosr_pkg::MOSR_FAXR;
				default: cur_mode <= mosr_pkg::MOSR_IDLE;
			endcase
			cur_std <= mosr_pkg::mosr_std_e'(CONFIG_STD);
		end
	end
	assign no_rate = (cur_std == mosr_pkg::MOSR_STD_V29) || (cur_std == mosr_pkg::MOSR_STD_V27);
	// edges of the scrambled ones flag as the host sees it
	assign ones_rise = cur_mode == mosr_pkg::MOSR_FAXR && cur_std == mosr_pkg::MOSR_STD_V33
		&& phase[mosr_pkg::PH_SCR1] && !scr1_d;
	assign ones_fall = cur_mode == mosr_pkg::MOSR_FAXR && scr1_d && !phase[mosr_pkg::PH_SCR1];

	// ----------------------------------------
	// negotiation byte
	// ----------------------------------------
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			neg_reg <= mosr_pkg::STAT_RESET;
		end else if (CONFIG_CMD) begin
			neg_reg <= mosr_pkg::STAT_RESET;
		end else if (cur_mode == mosr_pkg::MOSR_DATA) begin
			if (NEG_ACTIVE) begin
				neg_reg[mosr_pkg::NEG_DONE_BIT] <= 1'b0;
			end else if (NEG_DONE) begin
				neg_reg[mosr_pkg::NEG_DONE_BIT] <= 1'b1;
				if (NEGOTIATED_SPEED_CODE >= mosr_pkg::SPD_1200 && NEGOTIATED_SPEED_CODE <= mosr_pkg::SPD_MAX) begin
					neg_reg[mosr_pkg::SPD_MSB:mosr_pkg::SPD_LSB] <= NEGOTIATED_SPEED_CODE;
				end
			end
		end else if (ones_rise) begin
			neg_reg[mosr_pkg::SPD_MSB:mosr_pkg::SPD_LSB] <= RX_RATE_14400 ? mosr_pkg::SPD_14400 : mosr_pkg::SPD_12000;
			neg_reg[mosr_pkg::NEG_DONE_BIT] <= 1'b1;
		end
	end

	// speed valid with rising scrambled ones in V.33 receive
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			SPEED_VALID <= 1'b0;
		end else if (CONFIG_CMD || SYNC_ZERO) begin
			SPEED_VALID <= 1'b0;
		end else if (ones_rise) begin
			SPEED_VALID <= 1'b1;
		end
	end

	// ----------------------------------------
	// loop status byte
	// ----------------------------------------
	// 256 matching received bits
	mosr_count #(.LIMIT(mosr_pkg::V54_DET_BITS)) u_v54 (
		.clk(CLK),
		.rst_n(rst_n),
		.clear(CONFIG_CMD || (RX_BIT_STB && !RX_V54_MATCH)),
		.step(RX_BIT_STB && RX_V54_MATCH),
		.done(v54_done)
	);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			loop_reg <= mosr_pkg::STAT_RESET;
		end else if (CONFIG_CMD) begin
			loop_reg <= mosr_pkg::STAT_RESET;
		end else if (cur_mode == mosr_pkg::MOSR_DATA) begin
			loop_reg[mosr_pkg::LOOP_V54D] <= v54_done;
			if (TX_V54_END) loop_reg[mosr_pkg::LOOP_V54E] <= 1'b1;
			if (ALT_PATTERN_SEEN) loop_reg[mosr_pkg::LOOP_ALT] <= 1'b1;
			// loop pattern, upper bits stay zero
			if (LOOP_PATTERN_SEEN) loop_reg[mosr_pkg::LOOP_LOOP] <= 1'b1;
		end
	end

	// ----------------------------------------
	// phase byte: event code or fax flags
	// ----------------------------------------
	// one byte serves as event code in data mode and as flags in fax mode
	assign hshk_reg = phase;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			scr1_d <= 1'b0;
		end else begin
			scr1_d <= phase[mosr_pkg::PH_SCR1];
		end
	end

	// resample 256 bauds after ones fall
	mosr_count #(.LIMIT(mosr_pkg::RETRAIN_BAUDS)) u_retrain (
		.clk(CLK),
		.rst_n(rst_n),
		.clear(!retrain_armed && !ones_fall),
		.step(BAUD_STB),
		.done(retrain_done)
	);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			retrain_armed <= 1'b0;
		end else if (CONFIG_CMD || SYNC_ZERO || retrain_done) begin
			retrain_armed <= 1'b0;
		end else if (ones_fall) begin
			// the baud of the fall itself already counts
			retrain_armed <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			phase <= mosr_pkg::STAT_RESET;
		end else if (CONFIG_CMD) begin
			phase <= mosr_pkg::STAT_RESET;
		end else if (cur_mode == mosr_pkg::MOSR_DATA) begin
			if (HSHK_EVENT_STB) phase <= HSHK_EVENT_CODE;
		end else if (SYNC_ZERO) begin
			phase <= mosr_pkg::STAT_RESET;
		end else if (cur_mode == mosr_pkg::MOSR_FAXT) begin
			phase[mosr_pkg::PH_SCR1:mosr_pkg::PH_ECHO] <= TX_PHASE & {1'b1, !no_rate, 3'b111};
			if (SYNC_ONE && !(no_rate && rate_bit(SYNC_ONE_SEL))) begin
				phase[SYNC_ONE_SEL] <= 1'b1;
			end
		end else if (cur_mode == mosr_pkg::MOSR_FAXR) begin
			phase[mosr_pkg::PH_REV] <= RX_PHASE[0];
			phase[mosr_pkg::PH_SCR1] <= RX_PHASE[1];
			phase[mosr_pkg::PH_TRAIN] <= RX_TRAIN_DET;
			if (RX_TRAIN_DET) phase[mosr_pkg::PH_TDET] <= 1'b1;
			if (RX_RATE_DET && !no_rate) phase[mosr_pkg::PH_RDET] <= 1'b1;
			if (RX_TRAIN_END || retrain_done) phase[mosr_pkg::PH_SUCC] <= EQ_QUALITY_OK;
			// sync one, rate flags kept out in V.29, V.27
			if (SYNC_ONE && !(no_rate && rate_bit(SYNC_ONE_SEL))) begin
				phase[SYNC_ONE_SEL] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// echo protection interval
	// ----------------------------------------
	assign echo_start = cur_mode == mosr_pkg::MOSR_FAXT && SYNC_ONE && SYNC_ONE_SEL == 3'(mosr_pkg::PH_ECHO);
	// 192 ms guard only with long tone
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			echo_cnt <= 32'h00000000;
			ECHO_GUARD_ACTIVE <= 1'b0;
		end else if (CONFIG_CMD || SYNC_ZERO) begin
			echo_cnt <= 32'h00000000;
			ECHO_GUARD_ACTIVE <= 1'b0;
		end else if (echo_start && long_echo) begin
			echo_cnt <= 32'(mosr_pkg::ECHO_CYC - 1);
			ECHO_GUARD_ACTIVE <= 1'b1;
		end else if (echo_cnt != 32'h00000000) begin
			echo_cnt <= echo_cnt - 32'h00000001;
		end else begin
			ECHO_GUARD_ACTIVE <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_cfg_reload: assert property (@(posedge CLK) disable iff (!rst_n)
		CONFIG_CMD |=> (neg_reg == 8'h00 && loop_reg == 8'h00))
		else $error("status not reloaded after configuration");
	a_sync_clear: assert property (@(posedge CLK) disable iff (!rst_n)
		(SYNC_ZERO && !CONFIG_CMD && cur_mode != mosr_pkg::MOSR_DATA) |=> phase == 8'h00)
		else $error("sync zero left flags set");
	a_no_rate: assert property (@(posedge CLK) disable iff (!rst_n)
		(cur_mode != mosr_pkg::MOSR_DATA && no_rate && $stable(cur_std))
		|-> ##1 (!phase[mosr_pkg::PH_RATE] && !phase[mosr_pkg::PH_RDET]))
		else $error("rate flag in V.29 or V.27");
	a_loop_high: assert property (@(posedge CLK) disable iff (!rst_n)
		loop_reg[7:4] == 4'h0)
		else $error("reserved loop bits set");
	a_v54_sent: assert property (@(posedge CLK) disable iff (!rst_n)
		(TX_V54_END && cur_mode == mosr_pkg::MOSR_DATA && !CONFIG_CMD) |=> loop_reg[mosr_pkg::LOOP_V54E])
		else $error("loop sent bit not set");
	a_speed_code: assert property (@(posedge CLK) disable iff (!rst_n)
		(cur_mode == mosr_pkg::MOSR_DATA && neg_reg[0]) |-> neg_reg[4:1] <= mosr_pkg::SPD_MAX)
		else $error("illegal speed code");
	a_speed_valid_indicator_only: assert property (@(posedge CLK) disable iff (!rst_n)
		$rose(SPEED_VALID) |-> cur_std == mosr_pkg::MOSR_STD_V33 && $past(phase[mosr_pkg::PH_SCR1]))
		else $error("speed valid outside V.33 ones rise");
	a_no_write: assert property (@(posedge CLK) disable iff (!rst_n)
		(PREADY && PWRITE && PSEL && PADDR == mosr_pkg::ADDR_NEG) |-> PSLVERR)
		else $error("status write accepted");
endmodule
`default_nettype wire

// *** testbench/mosr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---
// apb host: request held until pready is seen high at a rising edge
// ---
module mosr_host_model (
	input wire logic clk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// no wait limit here: only the bench watchdog ends a dead wait
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** testbench/test_modem_optional_status.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_modem_optional_status;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, speed_valid, echo_act, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [10:0] stb;
	logic [3:0] cfg_mode, negotiated_speed_code;
	logic [2:0] cfg_std, sel;
	logic neg_active, v54_match, train_det, rate_det, eq_ok, r14400;
	logic [7:0] hcode;
	logic [4:0] tx_phase;
	logic [1:0] rx_phase;
	int err_total, cmp_count;
	mosr_status uut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CONFIG_CMD(stb[0]), .CONFIG_MODE(cfg_mode), .CONFIG_STD(cfg_std), .NEG_ACTIVE(neg_active),
		.NEG_DONE(stb[1]), .NEGOTIATED_SPEED_CODE(negotiated_speed_code), .RX_BIT_STB(stb[10]), .RX_V54_MATCH(v54_match),
		.TX_V54_END(stb[2]), .ALT_PATTERN_SEEN(stb[3]), .LOOP_PATTERN_SEEN(stb[4]),
		.HSHK_EVENT_STB(stb[5]), .HSHK_EVENT_CODE(hcode), .BAUD_STB(stb[9]), .TX_PHASE(tx_phase),
		.RX_PHASE(rx_phase), .RX_TRAIN_DET(train_det), .RX_RATE_DET(rate_det), .RX_TRAIN_END(stb[6]),
		.EQ_QUALITY_OK(eq_ok), .RX_RATE_14400(r14400), .SYNC_ZERO(stb[7]), .SYNC_ONE(stb[8]),
		.SYNC_ONE_SEL(sel), .SPEED_VALID(speed_valid), .ECHO_GUARD_ACTIVE(echo_act));
	mosr_host_model host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	always #50 clk = ~clk;
	// ---
	// helpers
	// ---
	task chk(input string nm, input logic [31:0] x, input logic [31:0] got);
		cmp_count++;
		if (got !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, got);
		end
	endtask
	task pulse(input int i);
		@(posedge clk);
		stb[i] <= 1'b1;
		@(posedge clk);
		stb <= '0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
		host.xfer(1'b0, a, 32'h0, d, e);
		chk(nm, x, d & m);
	endtask
	task cfg(input logic [3:0] m, input logic [2:0] s);
		@(posedge clk);
		cfg_mode <= m;
		cfg_std <= s;
		pulse(0);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ---
	// scenarios
	// ---
	task t_regs;
		rd(mosr_pkg::ADDR_NEG, 32'hFF, 32'h0, "neg_rst");
		host.xfer(1'b1, mosr_pkg::ADDR_NEG, 32'hFF, d, e);
		chk("wr_err", 32'h1, {31'h0, e});
		rd(mosr_pkg::ADDR_NEG, 32'hFF, 32'h0, "neg_ro");
		rd(mosr_pkg::ADDR_LOOP, 32'hFF, 32'h0, "loop_rst");
		rd(mosr_pkg::ADDR_HSHK, 32'hFF, 32'h0, "hshk_rst");
		rd(12'h044, 32'hFFFFFFFF, 32'h0, "unmapped");
	endtask
	task t_neg;
		cfg(mosr_pkg::MOSR_DATA, mosr_pkg::MOSR_STD_V21);
		neg_active <= 1'b1;
		rd(mosr_pkg::ADDR_NEG, 32'h01, 32'h0, "neg_busy");
		for (int i = 0; i < 2; i++) begin
			neg_active <= 1'b0;
			negotiated_speed_code <= i ? mosr_pkg::SPD_MAX : mosr_pkg::SPD_1200;
			pulse(1);
			rd(mosr_pkg::ADDR_NEG, 32'hFF, {27'h0, negotiated_speed_code, 1'b1}, "neg_done");
		end
		cfg(mosr_pkg::MOSR_DATA, mosr_pkg::MOSR_STD_V21);
		rd(mosr_pkg::ADDR_NEG, 32'hFF, 32'h0, "reload");
	endtask
	task t_loop;
		v54_match <= 1'b1;
		repeat (255) pulse(10);
		rd(mosr_pkg::ADDR_LOOP, 32'h01, 32'h0, "v54_early");
		pulse(10);
		rd(mosr_pkg::ADDR_LOOP, 32'h01, 32'h1, "v54_det");
		for (int i = 2; i < 5; i++) begin
			pulse(i);
			rd(mosr_pkg::ADDR_LOOP, 32'hFF, (32'h1 << i) - 32'h1, "loop_bits");
		end
		v54_match <= 1'b0;
	endtask
	task t_hshk;
		for (int i = 0; i < 3; i++) begin
			hcode <= 8'hFF >> (i * 4);
			pulse(5);
			rd(mosr_pkg::ADDR_HSHK, 32'hFF, {24'h0, hcode}, "hshk_code");
		end
	endtask
	task t_fax;
		cfg(mosr_pkg::MOSR_FAXT, mosr_pkg::MOSR_STD_V17);
		tx_phase <= 5'h1F;
		rd(mosr_pkg::ADDR_HSHK, 32'h1F, 32'h1F, "tx_flags");
		cfg(mosr_pkg::MOSR_FAXT, mosr_pkg::MOSR_STD_V29);
		rd(mosr_pkg::ADDR_HSHK, 32'h48, 32'h0, "v29_tx");
		tx_phase <= 5'h0;
		cfg(mosr_pkg::MOSR_FAXR, mosr_pkg::MOSR_STD_V17);
		r14400 <= 1'b1;
		rx_phase <= 2'b10;
		repeat (3) @(posedge clk);
		chk("speed_valid_indicator_v17", 32'h0, {31'h0, speed_valid});
		rx_phase <= 2'b00;
		cfg(mosr_pkg::MOSR_FAXR, mosr_pkg::MOSR_STD_V33);
		rx_phase <= 2'b10;
		repeat (3) @(posedge clk);
		chk("speed_valid_indicator_v33", 32'h1, {31'h0, speed_valid});
		rd(mosr_pkg::ADDR_NEG, 32'h1E, {27'h0, mosr_pkg::SPD_14400, 1'b0}, "v33_speed");
		train_det <= 1'b1;
		rate_det <= 1'b1;
		eq_ok <= 1'b1;
		pulse(6);
		rd(mosr_pkg::ADDR_HSHK, 32'hF0, 32'hF0, "rx_flags");
		eq_ok <= 1'b0;
		rx_phase <= 2'b00;
		repeat (255) pulse(9);
		rd(mosr_pkg::ADDR_HSHK, 32'h80, 32'h80, "succ_hold");
		pulse(9);
		rd(mosr_pkg::ADDR_HSHK, 32'h80, 32'h0, "succ_redo");
		train_det <= 1'b0;
		rate_det <= 1'b0;
		pulse(7);
		rd(mosr_pkg::ADDR_HSHK, 32'hFF, 32'h0, "sync_zero_command");
		sel <= 3'h5;
		pulse(8);
		rd(mosr_pkg::ADDR_HSHK, 32'h20, 32'h20, "sync_one_command");
		cfg(mosr_pkg::MOSR_FAXR, mosr_pkg::MOSR_STD_V29);
		rate_det <= 1'b1;
		sel <= 3'h3;
		pulse(8);
		sel <= 3'h6;
		pulse(8);
		rd(mosr_pkg::ADDR_HSHK, 32'h48, 32'h0, "v29_rx");
		rate_det <= 1'b0;
	endtask
	task t_echo;
		for (int i = 0; i < 2; i++) begin
			cfg(mosr_pkg::MOSR_FAXT, mosr_pkg::MOSR_STD_V17);
			host.xfer(1'b1, mosr_pkg::ADDR_CTRL, i ? 32'h10 : 32'h0, d, e);
			sel <= 3'h0;
			pulse(8);
			repeat (2) @(posedge clk);
			chk("echo_guard", i, {31'h0, echo_act});
		end
	endtask
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		stb = '0;
		{cfg_mode, negotiated_speed_code, cfg_std, sel, hcode, tx_phase, rx_phase} = '0;
		{neg_active, v54_match, train_det, rate_det, eq_ok, r14400} = '0;
		err_total = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs;
		t_neg;
		t_loop;
		t_hshk;
		t_fax;
		t_echo;
		complete_run;
	end
	// the whole run needs under 5000 cycles
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		complete_run;
	end
endmodule
`default_nettype wire
